// >>> hdl/mrrc_top.sv
// memory remap control, reset cause bookkeeping and reset sequencing
//
// Contract
// - 6 kB SRAM, 1536 words at 0x00040000
// - SRAM takes byte, halfword, word accesses
// - after reset, flash mapped at address zero
// - remap bit 0 selects SRAM at zero
// - every reset clears the remap bit
// - reset runs kernel, then reset vector in normal mode only
// - four reset sources recorded in status
// - clear register ones clear matching status bits
// - external pin reset sets status bit 3
// - watchdog reset sets status bit 1
// - power-on reset sets status bit 0
// - status bits 7..4 read zero
// - writing status bit 2 forces software reset
// - clear leaving bit 2 set re-resets
// - all resets reinit; only power-on resets watchdog
// - RAM invalid after download reset, valid after other non-power-on resets
// - low-voltage flag decides RAM validity after power-on
`timescale 1ns/1ps
`default_nettype none
module mrrc_top
(
    input  wire logic         i_clk,
    input  wire logic         i_srst,
    input  wire logic         i_bus_req,
    input  wire logic         i_bus_we,
    input  wire logic [3:0]   i_bus_be,
    input  wire logic [31:0]  i_bus_addr,
    input  wire logic [31:0]  i_bus_wdata,
    output logic [31:0]       o_bus_rdata,
    output logic              o_bus_ack,
    output logic              o_bus_abort,
    output logic              o_flash_req,
    output logic [31:0]       o_flash_addr,
    input  wire logic [31:0]  i_flash_rdata,
    input  wire logic         i_ext_reset,
    input  wire logic         i_wdt_reset,
    input  wire logic         i_download_done,
    input  wire logic         i_lvf_enable,
    input  wire logic         i_lvf_status,
    input  wire logic         i_normal_mode,
    input  wire logic         i_kernel_done,
    output logic              o_sys_reset,
    output logic              o_wdt_clear,
    output logic              o_kernel_start,
    output logic              o_jump_vector,
    output logic              o_ram_valid,
    output logic              o_remap_sram
);
    import mrrc_pkg::*;

    typedef struct packed
    {
        mrrc_state_e   state;
        logic [3:0]    hold_cnt;
        logic          remap;
        logic [3:0]    cause;
        logic          por_seen;
        logic          dl_seen;
        logic          pend;
        mrrc_target_e  tgt;
        logic [31:0]   reg_rdata;
        logic [31:0]   rdata;
        logic          ack;
        logic          abort;
        logic          flash_req;
        logic [31:0]   flash_addr;
        logic          sys_reset;
        logic          wdt_clear;
        logic          kernel_start;
        logic          jump_vector;
        logic          ram_valid;
    } mrrc_state_s;

    mrrc_state_s st_reg;
    mrrc_state_s st_next;

    logic [31:0]         sram_q;
    logic                sram_en;
    logic [SRAM_AW-1:0]  sram_addr;
    logic                take;
    logic                low_hit;
    logic                sram_hit;
    logic                flash_hit;
    logic [31:0]         low_off;

    // one request at a time; the answer cycle is skipped as well, since the
    // requester still holds the answered request at that edge
    assign take      = i_bus_req && !st_reg.pend && !st_reg.ack && (st_reg.state == MRRC_ST_RUN);
    assign low_hit   = i_bus_addr < LOW_BYTES;
    assign sram_hit  = (i_bus_addr >= SRAM_BASE) && (i_bus_addr < SRAM_BASE + SRAM_BYTES);
    assign flash_hit = (i_bus_addr >= FLASH_BASE) && (i_bus_addr < FLASH_BASE + FLASH_BYTES);
    assign low_off   = i_bus_addr;

    always_comb
    begin
        sram_en   = 1'b0;
        sram_addr = i_bus_addr[SRAM_AW+1:2];
        if (take)
        begin
            if (sram_hit)
            begin
                sram_en = 1'b1;
            end
            else if (low_hit && st_reg.remap && (low_off < SRAM_BYTES))
            begin
                sram_en = 1'b1;
            end
        end
    end

    always_comb
    begin
        logic       sw_trig;
        logic       ext_trig;
        logic       wdt_trig;
        logic [3:0] clr_mask;
        logic [3:0] set_mask;
        logic [3:0] wr_lane0;
        sw_trig  = 1'b0;
        ext_trig = i_ext_reset && (st_reg.state == MRRC_ST_RUN);
        wdt_trig = i_wdt_reset && (st_reg.state == MRRC_ST_RUN);
        clr_mask = 4'h0;
        set_mask = 4'h0;
        wr_lane0 = i_bus_wdata[3:0] & CAUSE_USED_MASK;

        st_next              = st_reg;
        st_next.ack          = 1'b0;
        st_next.abort        = 1'b0;
        st_next.flash_req    = 1'b0;
        st_next.kernel_start = 1'b0;
        st_next.jump_vector  = 1'b0;
        st_next.wdt_clear    = 1'b0;

        if (i_download_done)
        begin
            st_next.dl_seen = 1'b1;
        end

        // answer of the request taken in the previous cycle
        if (st_reg.pend)
        begin
            st_next.pend = 1'b0;
            st_next.ack  = 1'b1;
            unique case (st_reg.tgt)
                MRRC_TGT_REG:   st_next.rdata = st_reg.reg_rdata;
                MRRC_TGT_SRAM:  st_next.rdata = sram_q;
                MRRC_TGT_FLASH: st_next.rdata = i_flash_rdata;
                MRRC_TGT_ABORT:
                begin
                    st_next.rdata = 32'h0000_0000;
                    st_next.abort = 1'b1;
                end
            endcase
        end

        if (take)
        begin
            st_next.pend      = 1'b1;
            st_next.reg_rdata = 32'h0000_0000;
            if (sram_en)
            begin
                st_next.tgt = MRRC_TGT_SRAM;
            end
            else if (flash_hit || (low_hit && !st_reg.remap))
            begin
                st_next.tgt        = MRRC_TGT_FLASH;
                st_next.flash_req  = !i_bus_we;
                st_next.flash_addr = flash_hit ? i_bus_addr : (FLASH_BASE + low_off);
            end
            else if (i_bus_addr == MAP_SEL_ADDR)
            begin
                st_next.tgt       = MRRC_TGT_REG;
                st_next.reg_rdata = {31'h0000_0000, st_reg.remap};
                if (i_bus_we && i_bus_be[0])
                begin
                    // reserved bits are not stored, so they always read back zero
                    st_next.remap = i_bus_wdata[MAP_REMAP_BIT];
                end
            end
            else if (i_bus_addr == CAUSE_STAT_ADDR)
            begin
                st_next.tgt       = MRRC_TGT_REG;
                st_next.reg_rdata = {28'h000_0000, st_reg.cause};
                if (i_bus_we && i_bus_be[0] && i_bus_wdata[CAUSE_SW_BIT])
                begin
                    sw_trig = 1'b1;
                end
            end
            else if (i_bus_addr == CAUSE_CLR_ADDR)
            begin
                // write only: reads return zero
                st_next.tgt = MRRC_TGT_REG;
                if (i_bus_we && i_bus_be[0])
                begin
                    clr_mask = wr_lane0;
                    if (st_reg.cause[CAUSE_SW_BIT] && !wr_lane0[CAUSE_SW_BIT])
                    begin
                        sw_trig = 1'b1;
                    end
                end
            end
            else
            begin
                st_next.tgt = MRRC_TGT_ABORT;
            end
        end

        set_mask[CAUSE_EXT_BIT] = ext_trig;
        set_mask[CAUSE_WDT_BIT] = wdt_trig;
        set_mask[CAUSE_SW_BIT]  = sw_trig;
        // a source that fires in the same cycle as its clear stays recorded
        st_next.cause = (st_reg.cause & ~clr_mask) | set_mask;

        unique case (st_reg.state)
            MRRC_ST_RUN:
            begin
                if (ext_trig || wdt_trig || sw_trig)
                begin
                    st_next.state     = MRRC_ST_RESET;
                    st_next.hold_cnt  = HOLD_CNT_INIT;
                    st_next.sys_reset = 1'b1;
                    st_next.remap     = MAP_RST_VAL;
                end
            end
            MRRC_ST_RESET:
            begin
                st_next.remap = MAP_RST_VAL;
                if (st_reg.hold_cnt == 4'h0)
                begin
                    st_next.state        = MRRC_ST_KERNEL;
                    st_next.sys_reset    = 1'b0;
                    st_next.kernel_start = 1'b1;
                    // watchdog is cleared by power-on only
                    st_next.wdt_clear    = st_reg.por_seen;
                    if (st_reg.dl_seen)
                    begin
                        st_next.ram_valid = 1'b0;
                    end
                    else if (st_reg.por_seen)
                    begin
                        st_next.ram_valid = i_lvf_enable && i_lvf_status;
                    end
                    else
                    begin
                        st_next.ram_valid = 1'b1;
                    end
                    st_next.por_seen = 1'b0;
                    st_next.dl_seen  = 1'b0;
                end
                else
                begin
                    st_next.hold_cnt = st_reg.hold_cnt - 4'h1;
                end
            end
            MRRC_ST_KERNEL:
            begin
                // the kernel leaves through the vector only in normal mode
                if (i_kernel_done)
                begin
                    st_next.state       = MRRC_ST_RUN;
                    st_next.jump_vector = i_normal_mode;
                end
            end
        endcase
    end

    always_ff @(posedge i_clk)
    begin
        if (i_srst)
        begin
            st_reg              <= '0;
            st_reg.state        <= MRRC_ST_RESET;
            st_reg.hold_cnt     <= HOLD_CNT_INIT;
            st_reg.remap        <= MAP_RST_VAL;
            st_reg.cause        <= CAUSE_RST_VAL;
            st_reg.por_seen     <= 1'b1;
            st_reg.sys_reset    <= 1'b1;
            st_reg.tgt          <= MRRC_TGT_REG;
        end
        else
        begin
            st_reg <= st_next;
        end
    end

    mrrc_sram u_sram
    (
        .i_clk   (i_clk),
        .i_en    (sram_en),
        .i_we    (i_bus_we),
        .i_be    (i_bus_be),
        .i_addr  (sram_addr),
        .i_wdata (i_bus_wdata),
        .o_rdata (sram_q)
    );

    assign o_bus_rdata    = st_reg.rdata;
    assign o_bus_ack      = st_reg.ack;
    assign o_bus_abort    = st_reg.abort;
    assign o_flash_req    = st_reg.flash_req;
    assign o_flash_addr   = st_reg.flash_addr;
    assign o_sys_reset    = st_reg.sys_reset;
    assign o_wdt_clear    = st_reg.wdt_clear;
    assign o_kernel_start = st_reg.kernel_start;
    assign o_jump_vector  = st_reg.jump_vector;
    assign o_ram_valid    = st_reg.ram_valid;
    assign o_remap_sram   = st_reg.remap;
endmodule // mrrc_top
`default_nettype wire

// >>> hdl/mrrc_pkg.sv
// constants and types shared by the memory remap and reset cause block
package mrrc_pkg;
    localparam int          SRAM_WORDS      = 1536;
    localparam int          SRAM_AW         = 11;
    localparam logic [31:0] SRAM_BASE       = 32'h0004_0000;
    localparam logic [31:0] SRAM_BYTES      = 32'h0000_1800;
    localparam logic [31:0] LOW_BYTES       = 32'h0001_7800;
    localparam logic [31:0] FLASH_BASE      = 32'h0008_0000;
    localparam logic [31:0] FLASH_BYTES     = 32'h0001_8000;
    localparam logic [31:0] MAP_SEL_ADDR    = 32'hffff_0220;
    localparam logic [31:0] CAUSE_STAT_ADDR = 32'hffff_0230;
    localparam logic [31:0] CAUSE_CLR_ADDR  = 32'hffff_0234;
    localparam int          MAP_REMAP_BIT   = 0;
    localparam int          CAUSE_POR_BIT   = 0;
    localparam int          CAUSE_WDT_BIT   = 1;
    localparam int          CAUSE_SW_BIT    = 2;
    localparam int          CAUSE_EXT_BIT   = 3;
    localparam logic [3:0]  CAUSE_USED_MASK = 4'hf;
    localparam logic [3:0]  CAUSE_RST_VAL   = 4'h1;
    localparam logic        MAP_RST_VAL     = 1'b0;
    localparam int          CLK_MHZ         = 100;
    localparam int          RESET_HOLD_NS   = 100;
    localparam int          RESET_HOLD_CYC  = (RESET_HOLD_NS * CLK_MHZ + 999) / 1000;
    localparam logic [3:0]  HOLD_CNT_INIT   = 4'(RESET_HOLD_CYC - 1);

    typedef enum logic [1:0]
    {
        MRRC_ST_RUN    = 2'b00,
        MRRC_ST_RESET  = 2'b01,
        MRRC_ST_KERNEL = 2'b11
    } mrrc_state_e;

    typedef enum logic [1:0]
    {
        MRRC_TGT_REG   = 2'b00,
        MRRC_TGT_SRAM  = 2'b01,
        MRRC_TGT_FLASH = 2'b10,
        MRRC_TGT_ABORT = 2'b11
    } mrrc_target_e;
endpackage

// >>> hdl/mrrc_sram.sv
// 1536 x 32 volatile memory with byte lane write enables
`timescale 1ns/1ps
`default_nettype none
module mrrc_sram
(
    input  wire logic                          i_clk,
    input  wire logic                          i_en,
    input  wire logic                          i_we,
    input  wire logic [3:0]                    i_be,
    input  wire logic [mrrc_pkg::SRAM_AW-1:0]  i_addr,
    input  wire logic [31:0]                   i_wdata,
    output var  logic [31:0]                   o_rdata
);
    import mrrc_pkg::*;

    // contents are not reset: they survive warm resets by design
    logic [31:0] mem [SRAM_WORDS];

    always_ff @(posedge i_clk)
    begin
        if (i_en)
        begin
            if (i_we)
            begin
                for (int b = 0; b < 4; b++)
                begin
                    if (i_be[b])
                    begin
                        mem[i_addr][b*8 +: 8] <= i_wdata[b*8 +: 8];
                    end
                end
            end
            o_rdata <= mem[i_addr];
        end
    end
endmodule // mrrc_sram
`default_nettype wire

// >>> test/mrrc_top_props.sv
// port-level assertions for the memory remap and reset cause block
`timescale 1ns/1ps
`default_nettype none
module mrrc_top_props
(
    input  wire logic        i_clk,
    input  wire logic        i_srst,
    input  wire logic        i_bus_we,
    input  wire logic [31:0] i_bus_addr,
    input  wire logic [31:0] i_bus_wdata,
    input  wire logic        i_ext_reset,
    input  wire logic        i_wdt_reset,
    input  wire logic        i_normal_mode,
    input  wire logic        i_kernel_done,
    input  wire logic        o_bus_ack,
    input  wire logic        o_bus_abort,
    input  wire logic        o_flash_req,
    input  wire logic [31:0] o_flash_addr,
    input  wire logic        o_remap_sram,
    input  wire logic        o_sys_reset,
    input  wire logic        o_wdt_clear,
    input  wire logic        o_kernel_start,
    input  wire logic        o_jump_vector
);
    import mrrc_pkg::*;
    logic run_reg;
    logic por_reg;
    // run tracks when pin and watchdog resets are honoured; por tracks a pending power-on
    always_ff @(posedge i_clk)
    begin
        run_reg <= !i_srst && !o_sys_reset && (run_reg || i_kernel_done);
        por_reg <= i_srst || (por_reg && !o_kernel_start);
    end
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_srst);
    gap_abort_a: assert property (o_bus_ack && i_bus_addr inside {[32'h41800:32'h7ffff]}
        |-> o_bus_abort) else $error("gap access not aborted");
    flash_alias_a: assert property (o_flash_req && i_bus_addr < LOW_BYTES
        |-> !o_remap_sram && o_flash_addr == FLASH_BASE + i_bus_addr) else $error("bad alias");
    remap_set_a: assert property ($rose(o_remap_sram) |-> $past(i_bus_we) &&
        $past(i_bus_addr) == MAP_SEL_ADDR && $past(i_bus_wdata[0])) else $error("stray remap");
    remap_clear_a: assert property (o_sys_reset |-> !o_remap_sram)
        else $error("remap kept in reset");
    kernel_first_a: assert property ($fell(o_sys_reset) |-> ##[0:1] o_kernel_start)
        else $error("no kernel start");
    jump_mode_a: assert property (o_jump_vector |-> $past(i_normal_mode) && !o_sys_reset)
        else $error("jump outside normal mode");
    src_reset_a: assert property (run_reg && (i_ext_reset || i_wdt_reset) |=> o_sys_reset)
        else $error("reset source ignored");
    hold_len_a: assert property ($fell(o_sys_reset) |-> $past(o_sys_reset, 10))
        else $error("reset hold too short");
    wdt_por_a: assert property (o_kernel_start || o_wdt_clear
        |-> o_kernel_start && o_wdt_clear == por_reg) else $error("watchdog clear wrong");
endmodule // mrrc_top_props
bind mrrc_top mrrc_top_props props_i (.*);
`default_nettype wire

// >>> test/mrrc_top_tb_top.sv
// self-checking bench for the memory remap and reset cause block
`timescale 1ns/1ps
`default_nettype none
module mrrc_top_tb_top;
    import mrrc_pkg::*;
    logic        i_clk, i_srst, i_bus_req, i_bus_we, i_ext_reset, i_wdt_reset;
    logic        i_download_done, i_lvf_enable, i_lvf_status, i_normal_mode, i_kernel_done;
    logic [3:0]  i_bus_be;
    logic [31:0] i_bus_addr, i_bus_wdata, i_flash_rdata, o_bus_rdata, o_flash_addr;
    logic        o_bus_ack, o_bus_abort, o_flash_req, o_sys_reset, o_wdt_clear;
    logic        o_kernel_start, o_jump_vector, o_ram_valid, o_remap_sram;
    logic [33:0] exp_q[$];
    logic [33:0] e;
    logic [31:0] w0, w1;
    int          n_errors = 0;
    int          n_checks = 0;
    int          seed = 32'h2a0e;
    mrrc_top dut (.*);
    initial
    begin
        i_clk = 1'b0;
        forever #5 i_clk = ~i_clk;
    end
    task automatic summarize();
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task automatic tmo();
        n_errors++;
        summarize();
    endtask
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            n_errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // kernel handshake; bus is only served once it completes
    task automatic boot();
        int k;
        for (k = 0; k < 60 && o_kernel_start !== 1'b1; k++)
            @(posedge i_clk);
        if (k == 60)
            tmo();
        repeat (3) @(posedge i_clk);
        i_kernel_done <= 1'b1;
        @(posedge i_clk);
        i_kernel_done <= 1'b0;
    endtask
    // x: [33] data checked, [32] abort expected; 2'b11 means the write resets the system
    task automatic bus(input logic w, input logic [3:0] b, input logic [31:0] a,
                       input logic [31:0] d, input logic [33:0] x);
        int k;
        if (x[33:32] != 2'b11)
            exp_q.push_back(x);
        @(posedge i_clk);
        i_bus_req   <= 1'b1;
        i_bus_we    <= w;
        i_bus_be    <= b;
        i_bus_addr  <= a;
        i_bus_wdata <= d;
        for (k = 0; k < 20; k++)
        begin
            @(posedge i_clk);
            if ((x[33:32] == 2'b11 ? o_sys_reset : o_bus_ack) === 1'b1)
                break;
        end
        i_bus_req <= 1'b0;
        if (k == 20)
            tmo();
        if (x[33:32] == 2'b11)
            boot();
    endtask
    task automatic rd(input logic [31:0] a, input logic [31:0] v);
        bus(1'b0, 4'hf, a, 32'h0, {2'b10, v});
    endtask
    task automatic evt(input logic x, input logic w);
        @(posedge i_clk);
        i_ext_reset <= x;
        i_wdt_reset <= w;
        @(posedge i_clk);
        i_ext_reset <= 1'b0;
        i_wdt_reset <= 1'b0;
        boot();
    endtask
    // acks without a pending note are let through: a reset may cut a write short
    always @(posedge i_clk)
        if (o_bus_ack === 1'b1 && exp_q.size() > 0)
        begin
            e = exp_q.pop_front();
            cmp({31'h0, o_bus_abort}, {31'h0, e[32]});
            if (e[33])
                cmp(o_bus_rdata, e[31:0]);
        end
    initial
    begin
        i_srst = 1'b1;
        i_bus_req = 1'b0;
        i_bus_we = 1'b0;
        i_bus_be = 4'h0;
        i_bus_addr = 32'h0;
        i_bus_wdata = 32'h0;
        i_ext_reset = 1'b0;
        i_wdt_reset = 1'b0;
        i_download_done = 1'b0;
        i_lvf_enable = 1'b1;
        i_lvf_status = 1'b1;
        i_normal_mode = 1'b1;
        i_kernel_done = 1'b0;
        i_flash_rdata = $random(seed);
        w0 = $random(seed);
        w1 = $random(seed);
        repeat (20) @(posedge i_clk);
        i_srst <= 1'b0;
        boot();
        cmp({31'h0, o_ram_valid}, 32'h1);
        rd(MAP_SEL_ADDR, 32'h0);
        rd(CAUSE_STAT_ADDR, 32'h1);
        rd(CAUSE_CLR_ADDR, 32'h0);
        rd(32'h100, i_flash_rdata);
        bus(1'b1, 4'hf, SRAM_BASE, w0, 34'h0);
        bus(1'b1, 4'hf, 32'h417fc, w1, 34'h0);
        bus(1'b1, 4'h2, SRAM_BASE, 32'h5a00, 34'h0);
        bus(1'b1, 4'hc, 32'h417fc, 32'hbeef0000, 34'h0);
        w0[15:8] = 8'h5a;
        w1[31:16] = 16'hbeef;
        rd(SRAM_BASE, w0);
        rd(32'h417fc, w1);
        bus(1'b0, 4'hf, 32'h41800, 32'h0, {2'b01, 32'h0});
        bus(1'b1, 4'hf, MAP_SEL_ADDR, 32'h1, 34'h0);
        rd(MAP_SEL_ADDR, 32'h1);
        rd(32'h0, w0);
        rd(32'h17fc, w1);
        bus(1'b0, 4'hf, 32'h1800, 32'h0, {2'b01, 32'h0});
        bus(1'b1, 4'hf, CAUSE_CLR_ADDR, 32'hf0, 34'h0);
        rd(CAUSE_STAT_ADDR, 32'h1);
        bus(1'b1, 4'hf, CAUSE_CLR_ADDR, 32'h1, 34'h0);
        rd(CAUSE_STAT_ADDR, 32'h0);
        evt(1'b1, 1'b0);
        rd(CAUSE_STAT_ADDR, 32'h8);
        rd(MAP_SEL_ADDR, 32'h0);
        rd(SRAM_BASE, w0);
        cmp({31'h0, o_ram_valid}, 32'h1);
        evt(1'b0, 1'b1);
        rd(CAUSE_STAT_ADDR, 32'ha);
        bus(1'b1, 4'h1, CAUSE_STAT_ADDR, 32'h4, {2'b11, 32'h0});
        rd(CAUSE_STAT_ADDR, 32'he);
        bus(1'b1, 4'h1, CAUSE_CLR_ADDR, 32'h8, {2'b11, 32'h0});
        rd(CAUSE_STAT_ADDR, 32'h6);
        bus(1'b1, 4'hf, CAUSE_CLR_ADDR, 32'hf, 34'h0);
        rd(CAUSE_STAT_ADDR, 32'h0);
        i_normal_mode <= 1'b0;
        i_download_done <= 1'b1;
        @(posedge i_clk);
        i_download_done <= 1'b0;
        evt(1'b1, 1'b0);
        cmp({31'h0, o_ram_valid}, 32'h0);
        i_lvf_status <= 1'b0;
        i_srst <= 1'b1;
        repeat (20) @(posedge i_clk);
        i_srst <= 1'b0;
        boot();
        cmp({31'h0, o_ram_valid}, 32'h0);
        rd(CAUSE_STAT_ADDR, 32'h1);
        repeat (5) @(posedge i_clk);
        summarize();
    end
endmodule // mrrc_top_tb_top
`default_nettype wire
